/* hw/ssa_core.sv */
// axi4-lite slave around the subtract/swap/test datapath and its file registers
`timescale 1ns/1ps
// How it works
// RULE1 - subtract writes file minus accumulator back
// RULE2 - carry cleared on borrow, set otherwise
// RULE3 - half carry cleared on low-nibble borrow
// RULE4 - zero flag follows an all-zero difference
// RULE5 - programmed fuse adds inverted carry borrow-in
// RULE6 - carry carries bit-seven borrow for chaining
// RULE7 - swap exchanges nibbles, flags untouched
// RULE8 - test rewrites value, updates zero only
// RULE9 - five-bit operand picks file 00h..1Fh
// RULE10 - write and flags land in one cycle
module ssa_core #(
  parameter int FILE_DEPTH = 32
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // the operand field is five bits wide, so the file must match it
  if (FILE_DEPTH != (1 << ssa_pkg::FILE_IDX_W)) begin : g_bad_depth
    $error("ssa_core: file depth must match the operand field");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE, S_WACC, S_WDO, S_EXEC, S_BRESP, S_RACC, S_RDO, S_RMEM, S_RRESP
  } ssa_state_t;

  ssa_state_t state, next_state; // one bus transaction at a time
  logic [7:0] addr, next_addr; // latched bus address
  logic [31:0] data, next_data; // latched write data
  logic [3:0] strb, next_strb; // latched write strobes
  logic [7:0] acc, next_acc; // working accumulator
  ssa_pkg::ssa_flags_t flags, next_flags; // status flags
  logic borrow_in_enable_n, next_borrow_in_enable_n; // fuse bit, low enables
  logic [11:0] last_opcode, next_last_opcode; // instruction being run
  logic [7:0] last_result, next_last_result; // value written by it
  logic next_awready, next_wready, next_arready; // handshake readies
  logic next_bvalid, next_rvalid; // answer valids
  logic [1:0] next_bresp, next_rresp; // answer codes
  logic [31:0] next_rdata; // read answer data

  // memory port, driven straight from the next-state logic
  logic mem_we;
  logic [ssa_pkg::FILE_IDX_W-1:0] mem_waddr, mem_raddr;
  logic [7:0] mem_wdata, mem_rdata;

  ssa_pkg::ssa_op_t exec_op; // decoded operation of the latched opcode
  ssa_pkg::ssa_alu_out_t alu_res; // datapath answer

  // unused protection bits are accepted and ignored
  logic unused_prot;
  assign unused_prot = ^{s_axi_awprot, s_axi_arprot};

  // ----------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------
  assign exec_op = ssa_pkg::ssa_decode(last_opcode);

  ssa_alu u_alu (
    .op(exec_op),
    .file_register_operand(mem_rdata),
    .acc(acc),
    .flags_in(flags),
    .borrow_in_enable_n(borrow_in_enable_n),
    .res(alu_res)
  );

  ssa_file_mem #(
    .WIDTH(8),
    .DEPTH(FILE_DEPTH)
  ) u_mem (
    .clk_sys(clk_sys),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  // writes win the arbitration when both directions arrive together
  always_comb begin
    next_state = state;
    next_addr = addr;
    next_data = data;
    next_strb = strb;
    next_acc = acc;
    next_flags = flags;
    next_borrow_in_enable_n = borrow_in_enable_n;
    next_last_opcode = last_opcode;
    next_last_result = last_result;
    next_awready = 1'b0;
    next_wready = 1'b0;
    next_arready = 1'b0;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    mem_we = 1'b0;
    mem_waddr = addr[6:2];
    mem_wdata = data[7:0];
    mem_raddr = addr[6:2];
    case (state)
      S_IDLE: begin
        // raise both readies only once address and data are both offered
        if (s_axi_awvalid && s_axi_wvalid) begin
          next_awready = 1'b1;
          next_wready = 1'b1;
          next_state = S_WACC;
        end else if (s_axi_arvalid) begin
          next_arready = 1'b1;
          next_state = S_RACC;
        end
      end
      S_WACC: begin
        // both channels handshake at this edge
        next_addr = s_axi_awaddr;
        next_data = s_axi_wdata;
        next_strb = s_axi_wstrb;
        next_state = S_WDO;
      end
      S_WDO: begin
        next_bvalid = 1'b1;
        next_bresp = ssa_pkg::RESP_OKAY;
        next_state = S_BRESP;
        if (addr[ssa_pkg::FILE_SEL_POS]) begin
          mem_we = strb[0]; // direct file register write
        end else begin
          case (addr)
            ssa_pkg::OFS_INSTR: begin
              // unknown opcodes or strobes missing lane 0 or 1 are refused
              if (strb[1:0] == 2'h3 &&
                  ssa_pkg::ssa_decode(data[11:0]) != ssa_pkg::SSA_OP_NONE) begin
                next_last_opcode = data[11:0];
                mem_raddr = data[4:0]; // RULE9
                next_bvalid = 1'b0;
                next_state = S_EXEC;
              end else begin
                next_bresp = ssa_pkg::RESP_SLVERR;
              end
            end
            ssa_pkg::OFS_ACC: begin
              if (strb[0]) begin
                next_acc = data[7:0];
              end
            end
            ssa_pkg::OFS_STATUS: begin
              if (strb[0]) begin
                next_flags = data[2:0];
              end
            end
            ssa_pkg::OFS_FUSE: begin
              if (strb[0]) begin
                next_borrow_in_enable_n = data[ssa_pkg::FUSE_BIN_POS];
              end
            end
            default: begin
              next_bresp = ssa_pkg::RESP_SLVERR; // read-only or unmapped
            end
          endcase
        end
      end
      S_EXEC: begin
        // operand is in mem_rdata now; file write and flags share this edge
        mem_waddr = last_opcode[4:0]; // RULE9
        mem_we = alu_res.write_file; // RULE10
        mem_wdata = alu_res.value; // RULE1 RULE7 RULE8
        next_flags = alu_res.flags; // RULE10
        next_last_result = alu_res.value;
        next_bvalid = 1'b1;
        next_state = S_BRESP;
      end
      S_BRESP: begin
        if (s_axi_bready) begin
          next_bvalid = 1'b0;
          next_state = S_IDLE;
        end
      end
      S_RACC: begin
        next_addr = s_axi_araddr;
        next_state = S_RDO;
      end
      S_RDO: begin
        next_rresp = ssa_pkg::RESP_OKAY;
        next_rdata = 32'h0000_0000;
        if (addr[ssa_pkg::FILE_SEL_POS]) begin
          next_state = S_RMEM; // wait out the registered read
        end else begin
          next_rvalid = 1'b1;
          next_state = S_RRESP;
          case (addr)
            ssa_pkg::OFS_INSTR: next_rdata = {20'h00000, last_opcode};
            ssa_pkg::OFS_ACC: next_rdata = {24'h000000, acc};
            ssa_pkg::OFS_STATUS: next_rdata = {29'h00000000, flags};
            ssa_pkg::OFS_FUSE: next_rdata = {31'h00000000, borrow_in_enable_n};
            ssa_pkg::OFS_LAST: next_rdata = {8'h00, last_result, 4'h0, last_opcode};
            default: next_rresp = ssa_pkg::RESP_SLVERR;
          endcase
        end
      end
      S_RMEM: begin
        next_rdata = {24'h000000, mem_rdata};
        next_rvalid = 1'b1;
        next_state = S_RRESP;
      end
      S_RRESP: begin
        if (s_axi_rready) begin
          next_rvalid = 1'b0;
          next_state = S_IDLE;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= S_IDLE;
      addr <= 8'h00;
      data <= 32'h0000_0000;
      strb <= 4'h0;
      acc <= ssa_pkg::ACC_RST;
      flags <= ssa_pkg::FLAGS_RST;
      borrow_in_enable_n <= ssa_pkg::FUSE_BIN_RST;
      last_opcode <= ssa_pkg::LAST_RST;
      last_result <= 8'h00;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ssa_pkg::RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= ssa_pkg::RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
    end else begin
      state <= next_state;
      addr <= next_addr;
      data <= next_data;
      strb <= next_strb;
      acc <= next_acc;
      flags <= next_flags;
      borrow_in_enable_n <= next_borrow_in_enable_n;
      last_opcode <= next_last_opcode;
      last_result <= next_last_result;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_arready <= next_arready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic exec_sub; // subtract in its execute cycle
  assign exec_sub = (state == S_EXEC) && (exec_op == ssa_pkg::SSA_OP_SUB);

  chk_sub_result: assert property (@(posedge clk_sys) disable iff (rst) // RULE1
    exec_sub && borrow_in_enable_n |-> mem_we && mem_wdata == 8'(mem_rdata - acc)
      ##1 acc == $past(acc))
    else $error("subtract result or accumulator wrong");

  chk_sub_carry: assert property (@(posedge clk_sys) disable iff (rst) // RULE2
    exec_sub && borrow_in_enable_n |=> flags.c == ($past(mem_rdata) >= $past(acc)))
    else $error("subtract carry wrong");

  chk_sub_half: assert property (@(posedge clk_sys) disable iff (rst) // RULE3
    exec_sub && borrow_in_enable_n |=>
      flags.half_carry_flag == ($past(mem_rdata[3:0]) >= $past(acc[3:0])))
    else $error("subtract half carry wrong");

  chk_sub_zero: assert property (@(posedge clk_sys) disable iff (rst) // RULE4
    exec_sub |=> flags.z == (last_result == 8'h00))
    else $error("subtract zero flag wrong");

  chk_borrow_in: assert property (@(posedge clk_sys) disable iff (rst) // RULE5
    exec_sub && !borrow_in_enable_n && !flags.c |-> mem_wdata == 8'(mem_rdata - acc - 8'h01))
    else $error("borrow-in not applied");

  chk_chain_carry: assert property (@(posedge clk_sys) disable iff (rst) // RULE6
    exec_sub && !borrow_in_enable_n |=> flags.c ==
      (9'($past(mem_rdata)) >= 9'($past(acc)) + 9'(!$past(flags.c))))
    else $error("chained carry wrong");

  chk_swap_flags: assert property (@(posedge clk_sys) disable iff (rst) // RULE7
    state == S_EXEC && exec_op == ssa_pkg::SSA_OP_SWAP
      |-> mem_wdata == {mem_rdata[3:0], mem_rdata[7:4]} ##1 flags == $past(flags))
    else $error("swap wrong");

  chk_test_zero: assert property (@(posedge clk_sys) disable iff (rst) // RULE8
    state == S_EXEC && exec_op == ssa_pkg::SSA_OP_TEST |-> mem_we && mem_wdata == mem_rdata
      ##1 flags.z == ($past(mem_rdata) == 8'h00) && flags.c == $past(flags.c))
    else $error("test wrong");

  chk_file_index: assert property (@(posedge clk_sys) disable iff (rst) // RULE9
    state == S_WDO && next_state == S_EXEC |-> mem_raddr == data[4:0]
      ##1 mem_waddr == $past(data[4:0]))
    else $error("operand address wrong");

  chk_exec_single: assert property (@(posedge clk_sys) disable iff (rst) // RULE10
    state == S_WDO && next_state == S_EXEC |=> mem_we ##1 s_axi_bvalid && state == S_BRESP)
    else $error("execution not single cycle");

endmodule

/* hw/ssa_pkg.sv */
// shared constants, types and opcode decode for the subtract/swap/test datapath
package ssa_pkg;

  // ----------------------------------------------------------------
  // register map, byte addresses on the axi4-lite slave
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8; // slave address width
  localparam logic [7:0] OFS_INSTR = 8'h00; // instruction word, write executes
  localparam logic [7:0] OFS_ACC = 8'h04; // working accumulator
  localparam logic [7:0] OFS_STATUS = 8'h08; // z, half carry, carry
  localparam logic [7:0] OFS_FUSE = 8'h0c; // extended config fuse word
  localparam logic [7:0] OFS_LAST = 8'h10; // last opcode and result, read only
  localparam logic [7:0] OFS_FILE_BASE = 8'h80; // file registers, one word each
  localparam int FILE_SEL_POS = 7; // address bit that selects the file window

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int FLAG_C_POS = 0; // carry, 1 means no borrow
  localparam int FLAG_HALF_CARRY_POS = 1; // half carry
  localparam int FLAG_Z_POS = 2; // zero
  localparam int FUSE_BIN_POS = 0; // borrow_in_enable_n bit in fuse word
  localparam int LAST_RESULT_POS = 16; // result byte in the last register
  localparam logic [7:0] ACC_RST = 8'h00; // accumulator after reset
  localparam logic [2:0] FLAGS_RST = 3'h0; // status after reset
  localparam logic FUSE_BIN_RST = 1'b1; // unprogrammed fuse: no borrow-in
  localparam logic [11:0] LAST_RST = 12'h000; // last opcode after reset

  // ----------------------------------------------------------------
  // opcode layout: top seven bits select, low five address the file
  // ----------------------------------------------------------------
  localparam logic [6:0] OPC_SUB = 7'h05; // 0000 101f ffff
  localparam logic [6:0] OPC_SWAP = 7'h1d; // 0011 101f ffff
  localparam logic [6:0] OPC_TEST = 7'h11; // 0010 001f ffff
  localparam int FILE_IDX_W = 5; // operand field width

  // ----------------------------------------------------------------
  // bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0; // normal completion
  localparam logic [1:0] RESP_SLVERR = 2'h2; // unmapped or refused

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SSA_OP_NONE, SSA_OP_SUB, SSA_OP_SWAP, SSA_OP_TEST} ssa_op_t;

  // status bits, packed to match the status register layout
  typedef struct packed {
    logic z;
    logic half_carry_flag; // 1 means no borrow out of the low nibble
    logic c;
  } ssa_flags_t;

  // what the datapath hands back for one instruction
  typedef struct packed {
    logic [7:0] value;
    ssa_flags_t flags;
    logic write_file;
  } ssa_alu_out_t;

  // opcode word to operation, used by the bus decode and the datapath
  function automatic ssa_op_t ssa_decode(input logic [11:0] word);
    ssa_op_t op;
    op = SSA_OP_NONE;
    case (word[11:5])
      OPC_SUB: op = SSA_OP_SUB;
      OPC_SWAP: op = SSA_OP_SWAP;
      OPC_TEST: op = SSA_OP_TEST;
      default: op = SSA_OP_NONE;
    endcase
    return op;
  endfunction

endpackage

/* hw/ssa_file_mem.sv */
// file register storage with one write port and a registered read port
`timescale 1ns/1ps
module ssa_file_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk_sys,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (DEPTH < 2 || WIDTH < 1 || (1 << AW) < DEPTH) begin : g_bad
    $error("ssa_file_mem: unsupported width or depth");
  end

  logic [WIDTH-1:0] mem [DEPTH]; // contents, not reset like a real file

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // read data is registered, so a read lands one edge after its address;
  // a read and write of the same word in one cycle returns the old value
  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule

/* hw/ssa_alu.sv */
// combinational datapath for subtract, nibble swap and zero test
`timescale 1ns/1ps
module ssa_alu (
  input wire ssa_pkg::ssa_op_t op,
  input wire logic [7:0] file_register_operand,
  input wire logic [7:0] acc,
  input wire ssa_pkg::ssa_flags_t flags_in,
  input wire logic borrow_in_enable_n,
  output ssa_pkg::ssa_alu_out_t res
);

  logic borrow; // borrow-in taken from an inverted carry
  logic [8:0] diff; // full difference with borrow out on top
  logic [4:0] low_diff; // low nibble difference for the half carry

  // ----------------------------------------------------------------
  // arithmetic
  // ----------------------------------------------------------------
  always_comb begin
    borrow = ~borrow_in_enable_n & ~flags_in.c; // RULE5
    diff = {1'b0, file_register_operand} - {1'b0, acc} - {8'h00, borrow}; // RULE1
    low_diff = {1'b0, file_register_operand[3:0]} - {1'b0, acc[3:0]} - {4'h0, borrow};
    res = '{value: file_register_operand, flags: flags_in, write_file: 1'b0};
    case (op)
      ssa_pkg::SSA_OP_SUB: begin
        res.value = diff[7:0]; // RULE1
        res.flags.c = ~diff[8]; // RULE2 RULE6
        res.flags.half_carry_flag = ~low_diff[4]; // RULE3
        res.flags.z = (diff[7:0] == 8'h00); // RULE4
        res.write_file = 1'b1;
      end
      ssa_pkg::SSA_OP_SWAP: begin
        // flags pass straight through
        res.value = {file_register_operand[3:0], file_register_operand[7:4]}; // RULE7
        res.write_file = 1'b1;
      end
      ssa_pkg::SSA_OP_TEST: begin
        // value rewritten onto itself, only zero moves
        res.flags.z = (file_register_operand == 8'h00); // RULE8
        res.write_file = 1'b1;
      end
      default: begin
        res.write_file = 1'b0;
      end
    endcase
  end

endmodule

/* bench/testbench.sv */
// self-checking bench for the subtract, swap and test datapath over axi4-lite
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------
  // clock, reset and bus wires
  // ----------------------------------------
  logic clk_sys; // 100 mhz
  logic rst; // synchronous, active high
  logic [7:0] aw_addr;
  logic aw_valid;
  logic aw_ready;
  logic [31:0] w_data;
  logic [3:0] w_strb; // all lanes, except where a partial write is refused
  logic w_valid;
  logic w_ready;
  logic [1:0] b_resp;
  logic b_valid;
  logic b_ready;
  logic [7:0] ar_addr;
  logic ar_valid;
  logic ar_ready;
  logic [31:0] r_data;
  logic [1:0] r_resp;
  logic r_valid;
  logic r_ready;
  int error_cnt; // mismatches
  int n_checks; // comparisons made

  ssa_core #(.FILE_DEPTH(32)) uut (
    .clk_sys(clk_sys), .rst(rst),
    .s_axi_awaddr(aw_addr), .s_axi_awprot(3'h0), .s_axi_awvalid(aw_valid),
    .s_axi_awready(aw_ready), .s_axi_wdata(w_data), .s_axi_wstrb(w_strb),
    .s_axi_wvalid(w_valid), .s_axi_wready(w_ready), .s_axi_bresp(b_resp),
    .s_axi_bvalid(b_valid), .s_axi_bready(b_ready), .s_axi_araddr(ar_addr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(ar_valid), .s_axi_arready(ar_ready),
    .s_axi_rdata(r_data), .s_axi_rresp(r_resp), .s_axi_rvalid(r_valid),
    .s_axi_rready(r_ready)
  );

  // ----------------------------------------
  // clock
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // bus master tasks, all changes right after an edge
  // ----------------------------------------
  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk_sys);
    aw_addr <= a;
    w_data <= d;
    aw_valid <= 1'b1;
    w_valid <= 1'b1;
    b_ready <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (aw_valid && aw_ready) aw_valid <= 1'b0;
      if (w_valid && w_ready) w_valid <= 1'b0;
      if (b_valid === 1'b1) break;
    end
    b_ready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, b_resp});
  endtask

  // read: response data and code taken at the rvalid edge
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk_sys);
    ar_addr <= a;
    ar_valid <= 1'b1;
    r_ready <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (ar_valid && ar_ready) ar_valid <= 1'b0;
      if (r_valid === 1'b1) break;
    end
    r_ready <= 1'b0;
    chk("rresp", {30'h0, er}, {30'h0, r_resp});
    chk("rdata", ed, r_data);
  endtask

  // ----------------------------------------
  // instruction scenarios
  // ----------------------------------------
  function automatic logic [7:0] fa(input logic [4:0] f);
    return ssa_pkg::OFS_FILE_BASE + {1'b0, f, 2'b00};
  endfunction

  task automatic exec(input logic [6:0] opc, input logic [4:0] f);
    wr(ssa_pkg::OFS_INSTR, {20'h0, opc, f}, ssa_pkg::RESP_OKAY);
  endtask

  // subtract with expected result worked out here, seeded fuse and status
  task automatic run_sub(input logic [4:0] f, input logic [7:0] fv, input logic [7:0] w,
                         input logic fuse, input logic [2:0] st);
    logic bin;
    logic [8:0] full;
    logic [4:0] lo;
    logic [2:0] st_exp;
    bin = ~fuse & ~st[0];
    full = {1'b0, fv} - {1'b0, w} - {8'h0, bin};
    lo = {1'b0, fv[3:0]} - {1'b0, w[3:0]} - {4'h0, bin};
    st_exp = {full[7:0] == 8'h00, ~lo[4], ~full[8]};
    wr(fa(f), {24'h0, fv}, ssa_pkg::RESP_OKAY);
    wr(ssa_pkg::OFS_ACC, {24'h0, w}, ssa_pkg::RESP_OKAY);
    wr(ssa_pkg::OFS_FUSE, {31'h0, fuse}, ssa_pkg::RESP_OKAY);
    wr(ssa_pkg::OFS_STATUS, {29'h0, st}, ssa_pkg::RESP_OKAY);
    exec(ssa_pkg::OPC_SUB, f);
    rd(fa(f), {24'h0, full[7:0]}, ssa_pkg::RESP_OKAY);
    rd(ssa_pkg::OFS_STATUS, {29'h0, st_exp}, ssa_pkg::RESP_OKAY);
    rd(ssa_pkg::OFS_ACC, {24'h0, w}, ssa_pkg::RESP_OKAY);
  endtask

  // swap or zero test, flags seeded to see which ones move
  task automatic run_one(input logic [6:0] opc, input logic [4:0] f, input logic [7:0] v,
                         input logic [2:0] st);
    wr(fa(f), {24'h0, v}, ssa_pkg::RESP_OKAY);
    wr(ssa_pkg::OFS_STATUS, {29'h0, st}, ssa_pkg::RESP_OKAY);
    exec(opc, f);
    if (opc == ssa_pkg::OPC_SWAP) begin
      rd(fa(f), {24'h0, v[3:0], v[7:4]}, ssa_pkg::RESP_OKAY);
      rd(ssa_pkg::OFS_STATUS, {29'h0, st}, ssa_pkg::RESP_OKAY);
    end else begin
      rd(fa(f), {24'h0, v}, ssa_pkg::RESP_OKAY);
      rd(ssa_pkg::OFS_STATUS, {29'h0, v == 8'h00, st[1:0]}, ssa_pkg::RESP_OKAY);
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    {aw_addr, aw_valid, w_data, w_valid, b_ready} = '0;
    {ar_addr, ar_valid, r_ready} = '0;
    w_strb = 4'hf;
    error_cnt = 0;
    n_checks = 0;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    // reset values
    rd(ssa_pkg::OFS_ACC, 32'h0, ssa_pkg::RESP_OKAY);
    rd(ssa_pkg::OFS_STATUS, 32'h0, ssa_pkg::RESP_OKAY);
    rd(ssa_pkg::OFS_FUSE, 32'h1, ssa_pkg::RESP_OKAY);
    rd(ssa_pkg::OFS_LAST, 32'h0, ssa_pkg::RESP_OKAY);
    // plain, negative and zero differences, fuse unprogrammed
    run_sub(5'h0d, 8'h35, 8'h06, 1'b1, 3'h0);
    run_sub(5'h03, 8'h05, 8'h06, 1'b1, 3'h6);
    run_sub(5'h1f, 8'h42, 8'h42, 1'b1, 3'h0);
    // borrow-in only when fuse programmed and carry clear
    run_sub(5'h0a, 8'h10, 8'h05, 1'b0, 3'h0);
    run_sub(5'h0b, 8'h10, 8'h10, 1'b0, 3'h1);
    run_sub(5'h00, 8'h00, 8'h00, 1'b0, 3'h0);
    // chained 16-bit: low byte borrows out of bit 7, high byte takes it in
    run_sub(5'h0c, 8'h00, 8'h01, 1'b0, 3'h1);
    run_sub(5'h0d, 8'h05, 8'h02, 1'b0, 3'h0);
    // swap and zero test
    run_one(ssa_pkg::OPC_SWAP, 5'h0b, 8'ha5, 3'h5);
    run_one(ssa_pkg::OPC_SWAP, 5'h1f, 8'h3c, 3'h2);
    run_one(ssa_pkg::OPC_TEST, 5'h1b, 8'h00, 3'h3);
    run_one(ssa_pkg::OPC_TEST, 5'h1b, 8'h80, 3'h4);
    run_one(ssa_pkg::OPC_TEST, 5'h00, 8'h01, 3'h7);
    // last opcode and result of the final test
    rd(ssa_pkg::OFS_LAST, 32'h0001_0220, ssa_pkg::RESP_OKAY);
    // refusals: unknown opcode, read-only and unmapped places
    wr(ssa_pkg::OFS_INSTR, 32'h0000_0fff, ssa_pkg::RESP_SLVERR);
    // a legal opcode with its upper strobe lane missing is refused too
    w_strb <= 4'h1;
    wr(ssa_pkg::OFS_INSTR, {20'h0, ssa_pkg::OPC_SUB, 5'h00}, ssa_pkg::RESP_SLVERR);
    w_strb <= 4'hf;
    rd(ssa_pkg::OFS_LAST, 32'h0001_0220, ssa_pkg::RESP_OKAY);
    rd(fa(5'h00), 32'h0000_0001, ssa_pkg::RESP_OKAY);
    wr(ssa_pkg::OFS_LAST, 32'h0, ssa_pkg::RESP_SLVERR);
    rd(8'h14, 32'h0, ssa_pkg::RESP_SLVERR);
    end_sim();
  end

  // ----------------------------------------
  // watchdog: the whole sequence needs a few hundred cycles
  // ----------------------------------------
  initial begin
    #200000;
    error_cnt++;
    $display("[ERR] watchdog expected done seen timeout");
    end_sim();
  end
endmodule
